/* File: smc_defines.svh */
// Register offsets, field positions and reset values of the supply monitor block.
`ifndef SMC_DEFINES_SVH
`define SMC_DEFINES_SVH
`define SMC_ADDR_PSM      32'hFFFF0440
`define SMC_ADDR_CMP      32'hFFFF0444
`define SMC_ADDR_IRQ_STAT 32'hFFFF0448
`define SMC_ADDR_IRQ_MASK 32'hFFFF044C
`define SMC_PSM_RESET     16'h0008
`define SMC_CMP_RESET     16'h0000
`define SMC_PSM_LEVEL     3
`define SMC_PSM_TRIP      2
`define SMC_PSM_EN        1
`define SMC_PSM_FLAG      0
`define SMC_CMP_EN        10
`define SMC_CMP_NEG_HI    9
`define SMC_CMP_NEG_LO    8
`define SMC_CMP_ROUTE_HI  7
`define SMC_CMP_ROUTE_LO  6
`define SMC_CMP_POL       5
`define SMC_CMP_SPD_HI    4
`define SMC_CMP_SPD_LO    3
`define SMC_CMP_HYST      2
`define SMC_CMP_RISE      1
`define SMC_CMP_FALL      0
`define SMC_IRQ_LOW       0
`define SMC_IRQ_RISE      1
`define SMC_IRQ_FALL      2
`define SMC_IRQ_WIDTH     3
`define SMC_ROUTE_PIN     2'h2
`define SMC_ROUTE_IRQ     2'h3
`endif

/* File: smc_pkg.sv */
// Types shared by the supply monitor and comparator register block.
package smc_pkg;
    typedef enum logic [1:0] {
        SMC_ROUTE_RSV0_TYPE = 2'h0,
        SMC_ROUTE_RSV1_TYPE = 2'h1,
        SMC_ROUTE_PIN_TYPE  = 2'h2,
        SMC_ROUTE_IRQ_TYPE  = 2'h3
    } smc_route_type;
    typedef enum logic [1:0] {
        SMC_NEG_HALF_SUPPLY_TYPE = 2'h0,
        SMC_NEG_AIN3_TYPE        = 2'h1,
        SMC_NEG_DAC0_TYPE        = 2'h2,
        SMC_NEG_RSV_TYPE         = 2'h3
    } smc_neg_input_type;
endpackage

/* File: smc_regs.sv */
// APB register bank for the supply monitor and the general voltage comparator.
//
// Behaviour
// [RULE1] Level bit shows live supply state
// [RULE2] Trip select bit, zero means 2.79 V
// [RULE3] Monitor enable bit powers monitor circuit
// [RULE4] Level falling sets sticky low-supply flag
// [RULE5] Low-supply flag drives interrupt request
// [RULE6] Write one clears flag once level high
// [RULE7] Comparator enable bit switches comparator
// [RULE8] Negative input select field, code 11 reserved
// [RULE9] Routing: 10 drives pin, 11 interrupts
// [RULE10] Polarity bit inverts output sense
// [RULE11] Response speed field selects slow or fast
// [RULE12] Hysteresis bit enables about 7.5 mV
// [RULE13] Rising edge sets flag, write one clears
// [RULE14] Falling edge sets flag, holds until cleared
// [RULE15] Result routable to irq, logic, ADC, pin
// [RULE16] Low-supply irq gated by enable mask
// [RULE17] Falling flag cleared by writing one
// [RULE18] Comparator bits 15 to 11 read zero
`timescale 1ns/100ps
`include "smc_defines.svh"

module smc_regs (
    input  wire logic        pclk,              // Bus clock, 250 MHz.
    input  wire logic        presetn,           // Asynchronous reset, active low.
    input  wire logic        psel,              // APB select.
    input  wire logic        penable,           // APB enable.
    input  wire logic        pwrite,            // APB direction, high for write.
    input  wire logic [31:0] paddr,             // APB byte address.
    input  wire logic [31:0] pwdata,            // APB write data.
    output logic      [31:0] prdata,            // APB read data.
    output logic             pready,            // APB ready.
    output logic             pslverr,           // APB error on unmapped address.
    input  wire logic        supply_above_trip, // Supply comparator, high above trip.
    input  wire logic        comparator_raw,    // High when positive input above negative.
    output logic             supply_monitor_enable,  // Powers the supply monitor.
    output logic             trip_level_select,      // Trip point select to analog.
    output logic             comparator_enable,      // Powers the general comparator.
    output logic      [1:0]  negative_input_select,  // Negative input mux select.
    output logic      [1:0]  response_speed,         // Comparator speed select.
    output logic             hysteresis_enable,      // Comparator hysteresis on.
    output logic             comparator_result_pin,  // External comparator pin.
    output logic             comparator_to_logic,    // Result to logic array.
    output logic             adc_start,              // Conversion start pulse.
    output logic             low_supply_irq,         // Masked low-supply request.
    output logic             comparator_irq,         // Masked comparator request.
    output logic             irq                     // Combined level interrupt.
);

    logic [15:0] psm_ff;
    logic [15:0] cmp_ff;
    logic [`SMC_IRQ_WIDTH-1:0] mask_ff;
    logic        level_prev_ff;
    logic        result_ff;
    logic [31:0] prdata_ff;
    logic        pready_ff;
    logic        pslverr_ff;
    logic        out_pin_ff;
    logic        out_logic_ff;
    logic        adc_start_ff;
    logic        low_irq_ff;
    logic        cmp_irq_ff;
    logic        irq_ff;

    logic        level_now;
    logic        nxt_result;
    logic        setup;
    logic        wr_en;
    logic        wr_psm;
    logic        wr_cmp;
    logic        wr_mask;
    logic        low_set;
    logic        rise_set;
    logic        fall_set;
    logic [`SMC_IRQ_WIDTH-1:0] status;
    logic [`SMC_IRQ_WIDTH-1:0] w1c;
    smc_pkg::smc_route_type route;

    // Returns true when the address selects one of the four registers.
    function automatic logic is_mapped(input logic [31:0] a);
        is_mapped = (a == `SMC_ADDR_PSM) || (a == `SMC_ADDR_CMP) ||
                    (a == `SMC_ADDR_IRQ_STAT) || (a == `SMC_ADDR_IRQ_MASK);
    endfunction

    // Low-supply request: the flag is pending and its enable bit is set. The
    // enable bit stands in for the interrupt controller's own enable.
    function automatic logic low_request(input logic [`SMC_IRQ_WIDTH-1:0] s,
                                         input logic [`SMC_IRQ_WIDTH-1:0] m);
        low_request = s[`SMC_IRQ_LOW] & m[`SMC_IRQ_LOW];
    endfunction

    // Comparator request: an enabled edge flag is pending and the routing
    // field sends the result to the interrupt line; other codes keep it quiet.
    function automatic logic cmp_request(input smc_pkg::smc_route_type r,
                                         input logic [`SMC_IRQ_WIDTH-1:0] s,
                                         input logic [`SMC_IRQ_WIDTH-1:0] m);
        cmp_request = (r == smc_pkg::SMC_ROUTE_IRQ_TYPE) &
                      (|(s[`SMC_IRQ_FALL:`SMC_IRQ_RISE] & m[`SMC_IRQ_FALL:`SMC_IRQ_RISE]));
    endfunction

    // A powered-down monitor reads as a healthy supply.
    assign level_now = psm_ff[`SMC_PSM_EN] ? supply_above_trip : 1'b1; // RULE1

    // Polarity is applied before edge detection, so the flags follow the output sense.
    assign nxt_result = cmp_ff[`SMC_CMP_EN] &                        // RULE7
                        (comparator_raw ^ cmp_ff[`SMC_CMP_POL]);     // RULE10

    // Reserved routing codes are stored but drive neither the pin nor a request.
    assign route = smc_pkg::smc_route_type'(cmp_ff[`SMC_CMP_ROUTE_HI:`SMC_CMP_ROUTE_LO]);

    // Setup cycle of a transfer; the access cycle always follows with ready.
    assign setup = psel & ~penable;
    // A write lands only in the access cycle of a mapped address, so an
    // unmapped write can never alias onto a register.
    assign wr_en   = psel & penable & pwrite & pready_ff & ~pslverr_ff;
    assign wr_psm  = wr_en & (paddr == `SMC_ADDR_PSM);
    assign wr_cmp  = wr_en & (paddr == `SMC_ADDR_CMP);
    assign wr_mask = wr_en & (paddr == `SMC_ADDR_IRQ_MASK);

    assign low_set  = level_prev_ff & ~level_now;                    // RULE4
    assign rise_set = nxt_result & ~result_ff;                       // RULE13
    assign fall_set = ~nxt_result & result_ff;                       // RULE14

    // Shared status view; each bit aliases the flag in its owning register.
    assign status = {cmp_ff[`SMC_CMP_FALL], cmp_ff[`SMC_CMP_RISE],
                     psm_ff[`SMC_PSM_FLAG]};

    // Write-one-to-clear strobes, reachable through either the owning register
    // or the shared status register.
    always_comb begin
        w1c = '0;
        if (wr_en) begin
            case (paddr)
                `SMC_ADDR_PSM: begin
                    w1c[`SMC_IRQ_LOW] = pwdata[`SMC_PSM_FLAG];
                end
                `SMC_ADDR_CMP: begin
                    w1c[`SMC_IRQ_RISE] = pwdata[`SMC_CMP_RISE];
                    w1c[`SMC_IRQ_FALL] = pwdata[`SMC_CMP_FALL];
                end
                `SMC_ADDR_IRQ_STAT: begin
                    w1c = pwdata[`SMC_IRQ_WIDTH-1:0];
                end
                default: begin
                    w1c = '0;
                end
            endcase
        end
    end

    // Bus handshake: no wait states, data and ready both come from flip-flops.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff  <= setup;
            pslverr_ff <= setup & ~is_mapped(paddr);
        end
    end

    // Read data is captured in the setup cycle, so the level bit shows the
    // supply as it stood one cycle before the bus sees it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h0000_0000;
        end else if (setup && !pwrite) begin
            case (paddr)
                `SMC_ADDR_PSM: begin
                    prdata_ff <= {28'h000_0000, level_now,              // RULE1
                                  psm_ff[`SMC_PSM_TRIP],
                                  psm_ff[`SMC_PSM_EN],
                                  psm_ff[`SMC_PSM_FLAG]};
                end
                `SMC_ADDR_CMP: begin
                    prdata_ff <= {21'h00_0000, cmp_ff[`SMC_CMP_EN:`SMC_CMP_FALL]}; // RULE18
                end
                `SMC_ADDR_IRQ_STAT: begin
                    prdata_ff <= {29'h0000_0000, status};
                end
                `SMC_ADDR_IRQ_MASK: begin
                    prdata_ff <= {29'h0000_0000, mask_ff};
                end
                default: begin
                    prdata_ff <= 32'h0000_0000;
                end
            endcase
        end else begin
            prdata_ff <= 32'h0000_0000;
        end
    end

    // Supply monitor control and its sticky flag.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            psm_ff <= `SMC_PSM_RESET;
        end else begin
            if (wr_psm) begin
                psm_ff[`SMC_PSM_TRIP] <= pwdata[`SMC_PSM_TRIP];         // RULE2
                psm_ff[`SMC_PSM_EN]   <= pwdata[`SMC_PSM_EN];           // RULE3
            end
            // Clearing while the supply is still low is ignored; a set in the
            // same cycle as a clear wins.
            if (low_set) begin
                psm_ff[`SMC_PSM_FLAG] <= 1'b1;                          // RULE4
            end else if (w1c[`SMC_IRQ_LOW] && level_now) begin
                psm_ff[`SMC_PSM_FLAG] <= 1'b0;                          // RULE6
            end
        end
    end

    // Starts high to match the powered-down level, so reset raises no false flag.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level_prev_ff <= 1'b1;
        end else begin
            level_prev_ff <= level_now;
        end
    end

    // Comparator control fields; reserved upper bits are never stored.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_ff <= `SMC_CMP_RESET;
        end else begin
            if (wr_cmp) begin
                cmp_ff[`SMC_CMP_EN] <= pwdata[`SMC_CMP_EN];             // RULE7
                cmp_ff[`SMC_CMP_NEG_HI:`SMC_CMP_NEG_LO] <=
                    pwdata[`SMC_CMP_NEG_HI:`SMC_CMP_NEG_LO];            // RULE8
                cmp_ff[`SMC_CMP_ROUTE_HI:`SMC_CMP_ROUTE_LO] <=
                    pwdata[`SMC_CMP_ROUTE_HI:`SMC_CMP_ROUTE_LO];        // RULE9
                cmp_ff[`SMC_CMP_POL] <= pwdata[`SMC_CMP_POL];           // RULE10
                cmp_ff[`SMC_CMP_SPD_HI:`SMC_CMP_SPD_LO] <=
                    pwdata[`SMC_CMP_SPD_HI:`SMC_CMP_SPD_LO];            // RULE11
                cmp_ff[`SMC_CMP_HYST] <= pwdata[`SMC_CMP_HYST];         // RULE12
            end
            // A set in the same cycle as a clear wins, so no edge is lost.
            if (rise_set) begin
                cmp_ff[`SMC_CMP_RISE] <= 1'b1;                          // RULE13
            end else if (w1c[`SMC_IRQ_RISE]) begin
                cmp_ff[`SMC_CMP_RISE] <= 1'b0;                          // RULE13
            end
            if (fall_set) begin
                cmp_ff[`SMC_CMP_FALL] <= 1'b1;                          // RULE14
            end else if (w1c[`SMC_IRQ_FALL]) begin
                cmp_ff[`SMC_CMP_FALL] <= 1'b0;                          // RULE17
            end
        end
    end

    // Starts low like the gated result, so leaving reset is not an edge.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_ff <= 1'b0;
        end else begin
            result_ff <= nxt_result;
        end
    end

    // Interrupt mask, one bit per status bit.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_ff <= '0;
        end else if (wr_mask) begin
            mask_ff <= pwdata[`SMC_IRQ_WIDTH-1:0];                      // RULE16
        end
    end

    // Result routing. The logic array and conversion start always see the
    // result; only the pin and the interrupt depend on the routing field.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_pin_ff <= 1'b0;
        end else begin
            out_pin_ff <= (route == smc_pkg::SMC_ROUTE_PIN_TYPE) & nxt_result; // RULE9
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_logic_ff <= 1'b0;
        end else begin
            out_logic_ff <= nxt_result;                                // RULE15
        end
    end

    // One pulse per rising result edge, so a held-high result cannot start a
    // second conversion.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            adc_start_ff <= 1'b0;
        end else begin
            adc_start_ff <= rise_set;                                  // RULE15
        end
    end

    // Requests are levels that follow the flags one cycle late; each comes
    // from its own flip-flop so the pins never glitch while the flags settle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_irq_ff <= 1'b0;
        end else begin
            low_irq_ff <= low_request(status, mask_ff);                // RULE5 RULE16
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_irq_ff <= 1'b0;
        end else begin
            cmp_irq_ff <= cmp_request(route, status, mask_ff);         // RULE9 RULE15
        end
    end

    // The combined line is formed from the flags rather than from the two
    // request flip-flops, so it rises in the same cycle as they do.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= low_request(status, mask_ff) | cmp_request(route, status, mask_ff);
        end
    end

    // Every port below is a plain copy of a flip-flop.
    assign prdata                = prdata_ff;
    assign pready                = pready_ff;
    assign pslverr               = pslverr_ff;
    assign supply_monitor_enable = psm_ff[`SMC_PSM_EN];                 // RULE3
    assign trip_level_select     = psm_ff[`SMC_PSM_TRIP];               // RULE2
    assign comparator_enable     = cmp_ff[`SMC_CMP_EN];
    assign negative_input_select = cmp_ff[`SMC_CMP_NEG_HI:`SMC_CMP_NEG_LO];
    assign response_speed        = cmp_ff[`SMC_CMP_SPD_HI:`SMC_CMP_SPD_LO];
    assign hysteresis_enable     = cmp_ff[`SMC_CMP_HYST];
    assign comparator_result_pin = out_pin_ff;
    assign comparator_to_logic   = out_logic_ff;
    assign adc_start             = adc_start_ff;
    assign low_supply_irq        = low_irq_ff;
    assign comparator_irq        = cmp_irq_ff;
    assign irq                   = irq_ff;

endmodule

/* File: smc_regs_props.sv */
// Concurrent checks on the ports of the supply monitor register block.
`timescale 1ns/100ps
`include "smc_defines.svh"
module smc_regs_props (
    input wire logic        pclk,                  // Bus clock.
    input wire logic        presetn,               // Reset, active low.
    input wire logic        psel,                  // Select.
    input wire logic        penable,               // Enable.
    input wire logic        pwrite,                // Direction.
    input wire logic [31:0] paddr,                 // Address.
    input wire logic [31:0] pwdata,                // Write data.
    input wire logic [31:0] prdata,                // Read data.
    input wire logic        pready,                // Ready.
    input wire logic        pslverr,               // Error.
    input wire logic        supply_above_trip,     // Supply state.
    input wire logic        supply_monitor_enable, // Monitor on.
    input wire logic        comparator_enable,     // Comparator on.
    input wire logic [1:0]  negative_input_select, // Input mux.
    input wire logic        comparator_to_logic,   // Result.
    input wire logic        adc_start              // Start pulse.
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic acc;
    logic map;
    assign acc = psel && penable;
    assign map = (paddr[31:4] == 28'hFFFF044) && (paddr[1:0] == 2'h0);
    ready_after_setup_a: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    ready_only_access_a: assert property (!acc |-> !pready && prdata == 32'h0)
        else $error("ready or data outside access");
    unmapped_err_a: assert property (acc |-> pslverr == !map)
        else $error("error flag wrong");
    level_read_a: assert property (acc && !pwrite && paddr == `SMC_ADDR_PSM |->
        prdata[3] == ($past(supply_monitor_enable) ? $past(supply_above_trip) : 1'b1))
        else $error("level bit wrong");
    cmp_rsvd_a: assert property (acc && !pwrite && paddr == `SMC_ADDR_CMP |->
        prdata[31:11] == 21'h0) else $error("reserved bits not zero");
    mon_en_wr_a: assert property ($changed(supply_monitor_enable) && $past(presetn) |->
        $past(acc && pwrite && paddr == `SMC_ADDR_PSM) && supply_monitor_enable == $past(pwdata[1]))
        else $error("monitor enable changed without write");
    cmp_en_wr_a: assert property ($changed(comparator_enable) && $past(presetn) |->
        $past(acc && pwrite && paddr == `SMC_ADDR_CMP) && comparator_enable == $past(pwdata[10]))
        else $error("comparator enable changed without write");
    neg_sel_wr_a: assert property ($changed(negative_input_select) && $past(presetn) |->
        negative_input_select == $past(pwdata[9:8])) else $error("input select wrong");
    res_off_a: assert property (!comparator_enable && !$past(comparator_enable) |->
        !comparator_to_logic) else $error("result while disabled");
    adc_pulse_a: assert property (adc_start |=> !adc_start)
        else $error("start pulse too long");
    cover property (acc && pslverr);
    cover property (adc_start);
    cover property ($fell(supply_above_trip) && supply_monitor_enable);
endmodule
bind smc_regs smc_regs_props u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .supply_above_trip, .supply_monitor_enable, .comparator_enable,
    .negative_input_select, .comparator_to_logic, .adc_start);

/* File: smc_analog_model.sv */
// Behavioural model of the supply and general comparators feeding the block.
`timescale 1ns/100ps
module smc_analog_model (
    input  wire logic       pclk,              // Bus clock.
    input  wire logic       presetn,           // Reset, active low.
    input  wire logic       supply_ok,         // Commanded supply state.
    input  wire logic       cmp_hi,            // Commanded comparator state.
    input  wire logic [3:0] lag,               // Settling cycles, zero is prompt.
    output logic            supply_above_trip, // Supply above trip.
    output logic            comparator_raw     // Positive above negative.
);
    logic [3:0] cnt_ff;
    // Analog outputs settle only after the chosen delay, like a slow comparator.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            supply_above_trip <= 1'b1;
            comparator_raw <= 1'b0;
            cnt_ff <= 4'h0;
        end else if (cnt_ff >= lag) begin
            supply_above_trip <= supply_ok;
            comparator_raw <= cmp_hi;
            cnt_ff <= 4'h0;
        end else if (supply_ok != supply_above_trip || cmp_hi != comparator_raw) begin
            cnt_ff <= cnt_ff + 4'h1;
        end
    end
endmodule

/* File: smc_regs_tb.sv */
// Self-checking testbench of the supply monitor register block.
`timescale 1ns/100ps
`include "smc_defines.svh"
module smc_regs_tb;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, supply_ok = 1, cmp_hi = 0;
    logic [31:0] paddr = 0, pwdata = 0, prdata, d;
    logic [3:0] lag = 4'h0;
    logic pready, pslverr, supply_above_trip, comparator_raw, supply_monitor_enable, irq;
    logic trip_level_select, comparator_enable, hysteresis_enable, comparator_result_pin;
    logic comparator_to_logic, adc_start, low_supply_irq, comparator_irq;
    logic [1:0] negative_input_select, response_speed;
    logic [32:0] exp_q[$];
    int num_errors = 0, num_checks = 0, num_starts = 0, i;
    smc_regs dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .supply_above_trip, .comparator_raw, .supply_monitor_enable, .trip_level_select,
        .comparator_enable, .negative_input_select, .response_speed, .hysteresis_enable,
        .comparator_result_pin, .comparator_to_logic, .adc_start, .low_supply_irq,
        .comparator_irq, .irq);
    smc_analog_model u_analog (.pclk, .presetn, .supply_ok, .cmp_hi, .lag, .supply_above_trip,
        .comparator_raw);
    initial forever #2 pclk = ~pclk;
    task automatic check(input string what, input logic [32:0] seen, input logic [32:0] want);
        num_checks++;
        if (seen !== want) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, want, seen);
        end
    endtask
    task automatic apb(input logic [31:0] a, input logic w, input logic [31:0] v);
        @(posedge pclk);
        psel <= 1;
        paddr <= a;
        pwrite <= w;
        pwdata <= v;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 0;
        penable <= 0;
    endtask
    task automatic rd(input logic [31:0] a, input logic [32:0] e);
        exp_q.push_back(e);
        apb(a, 0, 32'h0);
    endtask
    task automatic await(input logic want);
        for (int n = 0; n < 30 && irq !== want; n++) @(posedge pclk);
        check("irq", irq, want);
    endtask
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite) check("read word", {pslverr, prdata},
            exp_q.pop_front());
    end
    always @(posedge pclk) begin
        if (adc_start === 1'b1) num_starts++;
    end
    task automatic stop_test();
        if (num_errors == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        #100000;
        num_errors++;
        stop_test();
    end
    initial begin
        void'($urandom(65));
        repeat (2) @(posedge pclk);
        presetn <= 1;
        rd(`SMC_ADDR_PSM, 33'h8);
        rd(`SMC_ADDR_CMP, 33'h0);
        rd(`SMC_ADDR_IRQ_MASK, 33'h0);
        apb(32'hFFFF0450, 1, 32'hFFFF);
        rd(32'hFFFF0450, 33'h100000000);
        apb(`SMC_ADDR_PSM, 1, 32'hF);
        rd(`SMC_ADDR_PSM, 33'hE);
        check("monitor controls", {supply_monitor_enable, trip_level_select}, 33'h3);
        apb(`SMC_ADDR_IRQ_MASK, 1, 32'h7);
        lag <= 4'h3;
        supply_ok <= 0;
        await(1);
        check("low supply irq", low_supply_irq, 1);
        apb(`SMC_ADDR_PSM, 1, 32'h7);
        rd(`SMC_ADDR_PSM, 33'h7);
        apb(`SMC_ADDR_IRQ_MASK, 1, 32'h6);
        repeat (2) @(posedge pclk);
        check("masked low irq", {low_supply_irq, irq}, 33'h0);
        apb(`SMC_ADDR_IRQ_MASK, 1, 32'h7);
        supply_ok <= 1;
        apb(`SMC_ADDR_PSM, 1, 32'h6);
        rd(`SMC_ADDR_PSM, 33'hF);
        apb(`SMC_ADDR_PSM, 1, 32'h7);
        rd(`SMC_ADDR_PSM, 33'hE);
        await(0);
        for (i = 0; i < 4; i++) begin
            d = $urandom() & 32'hFFFFFBDC | 32'h400;
            d[9:8] = i[1:0];
            d[7:6] = i[1:0];
            d[4:3] = i[1:0];
            apb(`SMC_ADDR_CMP, 1, d);
            rd(`SMC_ADDR_CMP, {1'b0, d & 32'h7FC});
            check("input and speed", {negative_input_select, response_speed}, {i[1:0], i[1:0]});
            check("enable and hysteresis", {comparator_enable, hysteresis_enable}, {1'b1, d[2]});
        end
        lag <= 4'h0;
        apb(`SMC_ADDR_CMP, 1, 32'h4C0);
        cmp_hi <= 1;
        await(1);
        check("comparator irq", comparator_irq, 1);
        rd(`SMC_ADDR_CMP, 33'h4C2);
        cmp_hi <= 0;
        repeat (4) @(posedge pclk);
        rd(`SMC_ADDR_CMP, 33'h4C3);
        apb(`SMC_ADDR_CMP, 1, 32'h4C1);
        rd(`SMC_ADDR_CMP, 33'h4C2);
        apb(`SMC_ADDR_IRQ_STAT, 1, 32'h2);
        rd(`SMC_ADDR_CMP, 33'h4C0);
        await(0);
        apb(`SMC_ADDR_CMP, 1, 32'h480);
        cmp_hi <= 1;
        repeat (4) @(posedge pclk);
        check("result outputs", {comparator_result_pin, comparator_to_logic}, 33'h3);
        apb(`SMC_ADDR_CMP, 1, 32'h4A0);
        repeat (2) @(posedge pclk);
        check("inverted outputs", {comparator_result_pin, comparator_to_logic}, 33'h0);
        check("start pulses", num_starts, 2);
        stop_test();
    end
endmodule
